// file: core/adc_seq_pkg.sv
package adc_seq_pkg;

    // ==========================================================
    // Sizes
    localparam int MAX_SLOTS = 64;
    localparam int SLOT_W    = 6;
    localparam int CH_W      = 5;
    localparam int DATA_W    = 12;
    localparam int NCONV     = 2;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESP_GAP_NS   = 1000;
    localparam int RESP_GAP_CYC  = (RESP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_NS      = 2000;
    localparam int PWRUP_CYC     = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONT_WIN_CYC  = 2;
    localparam int CNT_W         = 8;

    // ==========================================================
    // Channel codes
    localparam logic [CH_W-1:0] TSD_CH  = 5'h11;
    localparam logic [CH_W-1:0] TSD_SEL = 5'h00;

    // ==========================================================
    // Types
    typedef logic [MAX_SLOTS-1:0][CH_W-1:0]   slot_tbl_type;
    typedef logic [NCONV-1:0][31:0]           ch_mask_type;
    typedef logic [NCONV-1:0][DATA_W-1:0]     sample_type;

    typedef struct packed {
        logic              sop;
        logic              eop;
        logic [CH_W-1:0]   ch;
    } cmd_type;

    typedef struct packed {
        logic              sop;
        logic              eop;
        logic [CH_W-1:0]   ch;
        sample_type        data;
    } resp_type;

    typedef struct packed {
        logic [CH_W-1:0]   ch;
        logic [NCONV-1:0]  above;
        logic [NCONV-1:0]  below;
    } viol_type;

    typedef struct packed {
        logic              pd;
        logic              tsen;
        logic              soc;
        logic [CH_W-1:0]   sel;
    } hard_ctl_type;

    // Logical channel to converter select; the sensor has its own enable
    function automatic logic [CH_W-1:0] hard_sel(input logic [CH_W-1:0] ch);
        return (ch == TSD_CH) ? TSD_SEL : ch;
    endfunction : hard_sel

endpackage : adc_seq_pkg

// file: core/adc_sequencer_controller.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RL1: Command ready is high only when the control core can start a conversion.
// RL2: At most one command is held; none accepted while one is processed.
// RL3: Ready drops after acceptance and returns when the next command can start.
// RL4: Sequencer offers the next command within two cycles to keep sampling gapless.
// RL5: A command arriving later than two cycles after ready returns gets non-continuous sampling.
// RL6: Responses cannot be stalled; receivers take each one in its valid cycle.
// RL7: Two valid responses are never closer than one microsecond.
// RL8: Sequencer issues conversion commands following the stored channel sequence.
// RL9: A software mode bit selects the conversion mode.
// RL10: Sequence length and slot channels are build-time parameters.
// RL11: Storage writes each sample to on-chip RAM, readable by software.
// RL12: Storage optionally interrupts after each full sequence round.
// RL13: Dual variant merges simultaneous responses of both converters into one packet.
// RL14: Dual variant handshakes both converters so they proceed in step.
// RL15: Threshold detector flags samples above maximum or below minimum.
// RL16: Each violation goes out on a streaming output.
// RL17: Per-channel threshold enables and limits are build-time parameters; the limits here are one pair per converter, not per channel.
// RL18: Each converter has its own threshold settings.
// RL19: Only power up, power down, pin and temperature conversions exist.
// RL20: Logical channel numbers are translated to converter selections.
// RL21: Soft logic runs on mclk; converter side runs on the converter clock.
// RL22: The control core has no run-time settings.
// RL23: Single mode converts every slot once, then clears the run bit.
// RL24: Continuous mode wraps to the first slot while run stays set.
// RL25: Clearing run in continuous mode finishes the pass before stopping.
// RL26: Up to 64 slots, each with a selectable channel.
// RL27: Storage writes slot-indexed entries, index reset at each round start.
// RL28: Interrupt holds until acknowledged and is masked by its enable.
module adc_sequencer_controller
    import adc_seq_pkg::*;
#(
    parameter int           SEQ_LEN  = 4,
    parameter slot_tbl_type SLOT_CH  = '0,
    parameter slot_tbl_type SLOT_CH2 = '0,
    parameter bit           DUAL     = 1'b0,
    parameter ch_mask_type  MAX_EN   = '0,
    parameter ch_mask_type  MIN_EN   = '0,
    parameter sample_type   TH_MAX   = '1,
    parameter sample_type   TH_MIN   = '0
)(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // Software control
    input  wire logic                   run_set,
    input  wire logic                   run_clr,
    input  wire logic                   mode_cont,
    input  wire logic                   pwr_down_req,
    output logic                        run_bit,
    output logic                        busy,
    // Sample readout and interrupt
    input  wire logic [SLOT_W-1:0]      rd_addr,
    output logic [NCONV*DATA_W-1:0]     rd_data,
    input  wire logic                   irq_en,
    input  wire logic                   irq_ack,
    output logic                        irq,
    // Response stream
    output logic                        resp_valid,
    output resp_type                    resp,
    // Violation stream
    output logic                        viol_valid,
    output viol_type                    viol,
    // Converter hard block
    input  wire logic                   conv_clk,
    input  wire logic [NCONV-1:0]       conv_eoc,
    input  wire sample_type             conv_dout,
    output hard_ctl_type [NCONV-1:0]    conv_ctl
);

    // ==========================================================
    // Pin synchronisers
    localparam int SYN_W = 1 + NCONV + NCONV * DATA_W;
    logic [SYN_W-1:0] syn1_ff;
    logic [SYN_W-1:0] syn2_ff;
    logic [NCONV:0]   edge_ff;
    logic             clk_rise;
    logic [NCONV-1:0] eoc_rise;
    sample_type       dout_s;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            syn1_ff <= '0;
            syn2_ff <= '0;
            edge_ff <= '0;
        end
        else
        begin
            syn1_ff <= {conv_clk, conv_eoc, conv_dout};
            syn2_ff <= syn1_ff;
            edge_ff <= syn2_ff[SYN_W-1 -: NCONV+1];
        end
    end

    // Converter clock is only sampled, so its edges arrive two mclk late
    assign clk_rise = syn2_ff[SYN_W-1] & ~edge_ff[NCONV]; // see RL21
    assign eoc_rise = syn2_ff[SYN_W-2 -: NCONV] & ~edge_ff[NCONV-1:0];
    assign dout_s   = syn2_ff[NCONV*DATA_W-1:0];

    // ==========================================================
    // Sequencer
    logic              run_ff, nxt_run;
    logic              act_ff, nxt_act;
    logic [SLOT_W-1:0] slot_ff, nxt_slot;
    logic              cmd_valid;
    logic              cmd_ready;
    logic              cmd_take;
    cmd_type           cmd;
    logic              last_slot;

    assign cmd_valid = act_ff; // see RL4
    assign cmd_take  = cmd_valid & cmd_ready;
    assign last_slot = (slot_ff == SLOT_W'(SEQ_LEN - 1));
    assign cmd.sop   = (slot_ff == '0);
    assign cmd.eop   = last_slot;
    assign cmd.ch    = SLOT_CH[slot_ff]; // see RL8, RL10, RL26

    always_comb
    begin
        nxt_run  = run_ff;
        nxt_act  = act_ff;
        nxt_slot = slot_ff;
        if (run_clr)
            nxt_run = 1'b0;
        if (!act_ff && run_ff)
            nxt_act = 1'b1;
        if (cmd_take)
        begin
            nxt_slot = last_slot ? '0 : slot_ff + 1'b1;
            if (last_slot && !(mode_cont && run_ff && !run_clr)) // see RL9, RL24, RL25
            begin
                nxt_act = 1'b0;
                if (!mode_cont)
                    nxt_run = 1'b0; // see RL23
            end
        end
        if (run_set)
            nxt_run = 1'b1;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            run_ff  <= 1'b0;
            act_ff  <= 1'b0;
            slot_ff <= '0;
        end
        else
        begin
            run_ff  <= nxt_run;
            act_ff  <= nxt_act;
            slot_ff <= nxt_slot;
        end
    end

    // ==========================================================
    // Control core; nothing here is software adjustable (see RL22)
    typedef enum logic [4:0] {
        ST_OFF   = 5'b0_0001,
        ST_PWRUP = 5'b0_0010,
        ST_RDY   = 5'b0_0100,
        ST_CONV  = 5'b0_1000,
        ST_DONE  = 5'b1_0000
    } ctl_state_type;

    ctl_state_type    st_ff, nxt_st;
    cmd_type          cur_ff, nxt_cur;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] since_ff, nxt_since;
    logic             cont_ff, nxt_cont;
    logic             soc_ff, nxt_soc;
    logic [NCONV-1:0] done_ff, nxt_done;
    sample_type       smp_ff, nxt_smp;
    logic [NCONV-1:0] used;

    assign used      = DUAL ? {NCONV{1'b1}} : NCONV'(1);
    assign cmd_ready = (st_ff == ST_RDY); // see RL1, RL2, RL3

    always_comb
    begin
        nxt_st    = st_ff;
        nxt_cur   = cur_ff;
        nxt_cnt   = cnt_ff;
        nxt_cont  = cont_ff;
        nxt_soc   = soc_ff;
        nxt_done  = done_ff;
        nxt_smp   = smp_ff;
        nxt_since = (since_ff == '1) ? since_ff : since_ff + 1'b1;
        unique case (st_ff)
            ST_OFF:
                if (cmd_valid && !pwr_down_req) // see RL19
                begin
                    nxt_st  = ST_PWRUP;
                    nxt_cnt = CNT_W'(PWRUP_CYC - 1);
                end
            ST_PWRUP:
                if (cnt_ff == '0)
                    nxt_st = ST_RDY;
                else
                    nxt_cnt = cnt_ff - 1'b1;
            ST_RDY:
                if (pwr_down_req && !cmd_valid)
                begin
                    nxt_st  = ST_OFF; // see RL19
                    nxt_soc = 1'b0;
                end
                else if (cmd_take)
                begin
                    nxt_st    = ST_CONV; // see RL2
                    nxt_cur   = cmd;
                    nxt_done  = '0;
                    nxt_since = '0;
                    nxt_cont  = (since_ff <= CNT_W'(CONT_WIN_CYC)); // see RL5
                    if (!nxt_cont)
                        nxt_soc = 1'b0;
                end
            ST_CONV:
            begin
                // Start is launched on a converter clock edge only
                if (clk_rise)
                    nxt_soc = 1'b1; // see RL21
                for (int i = 0; i < NCONV; i++)
                    if (soc_ff && eoc_rise[i] && used[i])
                    begin
                        nxt_done[i] = 1'b1;
                        nxt_smp[i]  = dout_s[i];
                    end
                // In the dual variant both converters finish before either moves on
                if ((nxt_done & used) == used) // see RL14
                    nxt_st = ST_DONE;
            end
            ST_DONE:
            begin
                nxt_st = ST_RDY; // see RL3
                // Window for the next command opens as ready returns, not at the last take
                nxt_since = '0; // see RL5
                if (!cont_ff)
                    nxt_soc = 1'b0; // see RL5
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            st_ff    <= ST_OFF;
            cur_ff   <= '0;
            cnt_ff   <= '0;
            since_ff <= '1;
            cont_ff  <= 1'b0;
            soc_ff   <= 1'b0;
            done_ff  <= '0;
            smp_ff   <= '0;
        end
        else
        begin
            st_ff    <= nxt_st;
            cur_ff   <= nxt_cur;
            cnt_ff   <= nxt_cnt;
            since_ff <= nxt_since;
            cont_ff  <= nxt_cont;
            soc_ff   <= nxt_soc;
            done_ff  <= nxt_done;
            smp_ff   <= nxt_smp;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NCONV; i++)
        begin
            conv_ctl[i].pd   = (st_ff == ST_OFF) || !used[i];
            conv_ctl[i].soc  = soc_ff & used[i];
            conv_ctl[i].tsen = (cur_ff.ch == TSD_CH) && (i == 0);
            conv_ctl[i].sel  = hard_sel(cur_ff.ch); // see RL20
        end
    end

    // ==========================================================
    // Response pacing and merge
    logic             pend_ff, nxt_pend;
    logic [CNT_W-1:0] gap_ff, nxt_gap;
    logic             rv_ff, nxt_rv;
    resp_type         resp_ff, nxt_resp;

    always_comb
    begin
        nxt_pend = pend_ff;
        nxt_gap  = (gap_ff == '0) ? gap_ff : gap_ff - 1'b1;
        nxt_rv   = 1'b0;
        nxt_resp = resp_ff;
        if (st_ff == ST_DONE)
        begin
            nxt_pend = 1'b1;
            nxt_resp = {cur_ff.sop, cur_ff.eop, cur_ff.ch, smp_ff}; // see RL13
        end
        // Held until the pacing allows; a newer sample arriving meanwhile overwrites it
        else if (pend_ff && gap_ff == '0)
        begin
            nxt_pend = 1'b0;
            nxt_rv   = 1'b1; // see RL6
            nxt_gap  = CNT_W'(RESP_GAP_CYC - 1); // see RL7
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pend_ff <= 1'b0;
            gap_ff  <= '0;
            rv_ff   <= 1'b0;
            resp_ff <= '0;
        end
        else
        begin
            pend_ff <= nxt_pend;
            gap_ff  <= nxt_gap;
            rv_ff   <= nxt_rv;
            resp_ff <= nxt_resp;
        end
    end

    assign resp_valid = rv_ff;
    assign resp       = resp_ff;

    // ==========================================================
    // Sample storage
    logic [NCONV*DATA_W-1:0] ram [MAX_SLOTS];
    logic [SLOT_W-1:0]       wr_idx;
    logic [SLOT_W-1:0]       idx_ff, nxt_idx;
    logic                    flag_ff, nxt_flag;
    logic [NCONV*DATA_W-1:0] rd_ff;

    assign wr_idx = resp_ff.sop ? '0 : idx_ff; // see RL27

    always_comb
    begin
        nxt_idx  = idx_ff;
        nxt_flag = flag_ff;
        if (irq_ack)
            nxt_flag = 1'b0;
        if (rv_ff)
        begin
            nxt_idx = wr_idx + 1'b1;
            if (resp_ff.eop)
                nxt_flag = 1'b1; // see RL12
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            idx_ff  <= '0;
            flag_ff <= 1'b0;
        end
        else
        begin
            idx_ff  <= nxt_idx;
            flag_ff <= nxt_flag;
        end
    end

    // RAM carries no reset, so it maps onto block memory
    always_ff @(posedge mclk)
    begin
        if (rv_ff)
            ram[wr_idx] <= resp_ff.data; // see RL11
        rd_ff <= ram[rd_addr]; // see RL11
    end

    assign rd_data = rd_ff;
    assign irq     = flag_ff & irq_en; // see RL28

    // ==========================================================
    // Threshold detection
    logic     vv_ff, nxt_vv;
    viol_type viol_ff, nxt_viol;

    always_comb
    begin
        nxt_viol    = viol_ff;
        nxt_viol.ch = resp_ff.ch;
        nxt_vv      = 1'b0;
        for (int i = 0; i < NCONV; i++)
        begin
            // Limits are per converter; the second may watch other channels
            nxt_viol.above[i] = used[i] && MAX_EN[i][resp_ff.ch]
                                && (resp_ff.data[i] > TH_MAX[i]); // see RL15, RL17, RL18
            nxt_viol.below[i] = used[i] && MIN_EN[i][resp_ff.ch]
                                && (resp_ff.data[i] < TH_MIN[i]); // see RL15, RL17, RL18
        end
        nxt_vv = rv_ff && ((nxt_viol.above | nxt_viol.below) != '0); // see RL16
        if (!rv_ff)
            nxt_viol = viol_ff;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            vv_ff   <= 1'b0;
            viol_ff <= '0;
        end
        else
        begin
            vv_ff   <= nxt_vv;
            viol_ff <= nxt_viol;
        end
    end

    assign viol_valid = vv_ff;
    assign viol       = viol_ff;
    assign run_bit    = run_ff;
    assign busy       = act_ff | (st_ff != ST_RDY && st_ff != ST_OFF);

endmodule : adc_sequencer_controller

`default_nettype wire

// file: verif/adc_seq_checker_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adc_seq_checker
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset,
    // Software control
    input  wire logic                     run_set,
    input  wire logic                     run_bit,
    input  wire logic                     busy,
    input  wire logic                     irq_en,
    input  wire logic                     irq_ack,
    input  wire logic                     irq,
    // Streams
    input  wire logic                     resp_valid,
    input  wire resp_type                 resp,
    input  wire logic                     viol_valid,
    input  wire viol_type                 viol,
    // Converter
    input  wire hard_ctl_type [NCONV-1:0] conv_ctl
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // ==========================================================
    // Steps
    sequence s_quiet;
        (!resp_valid) [*8] ##1 !resp_valid;
    endsequence
    sequence s_judged;
        resp_valid ##1 viol_valid;
    endsequence

    // ==========================================================
    // Properties
    a_resp_gap: assert property (resp_valid |=> s_quiet)
        else $error("responses closer than one microsecond");
    a_viol_cause: assert property (viol_valid |-> $past(resp_valid))
        else $error("violation without a response before it");
    a_viol_chan: assert property (s_judged |-> viol.ch == $past(resp.ch))
        else $error("violation channel differs from judged sample");
    a_pd_nosoc: assert property (conv_ctl[0].pd |-> !conv_ctl[0].soc)
        else $error("conversion started while powered down");
    a_tsd_sel: assert property (conv_ctl[0].tsen |-> conv_ctl[0].sel == TSD_SEL)
        else $error("sensor enable with wrong select");
    a_irq_mask: assert property (!irq_en |-> !irq)
        else $error("interrupt while disabled");
    a_irq_hold: assert property ((irq && !irq_ack) ##1 irq_en |-> irq)
        else $error("interrupt dropped without acknowledge");
    a_run_set: assert property (run_set |=> run_bit)
        else $error("run bit not set");
    a_busy_after: assert property ($rose(run_bit) |=> busy)
        else $error("sequencer not active after run");
    // A middle slot follows a promptly offered command, so its start must still stand
    a_cont_soc: assert property (resp_valid && !resp.sop && !resp.eop |-> conv_ctl[0].soc)
        else $error("start dropped although the next command came in time");
    c_round: cover property (resp_valid && resp.eop);
endmodule : adc_seq_checker

bind adc_sequencer_controller adc_seq_checker chk_u (
    .mclk       (mclk),
    .reset      (reset),
    .run_set    (run_set),
    .run_bit    (run_bit),
    .busy       (busy),
    .irq_en     (irq_en),
    .irq_ack    (irq_ack),
    .irq        (irq),
    .resp_valid (resp_valid),
    .resp       (resp),
    .viol_valid (viol_valid),
    .viol       (viol),
    .conv_ctl   (conv_ctl)
);
`default_nettype wire

// file: verif/adc_hard_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_hard_model
    import adc_seq_pkg::*;
(
    // Converter clock
    input  wire logic                     conv_clk,
    // Control from the block
    input  wire hard_ctl_type [NCONV-1:0] conv_ctl,
    // Results back
    output logic [NCONV-1:0]              conv_eoc,
    output sample_type                    conv_dout
);
    for (genvar i = 0; i < NCONV; i++)
    begin : g_conv
        logic [1:0] cnt;
        initial
        begin
            cnt          = 2'h0;
            conv_eoc[i]  = 1'b0;
            conv_dout[i] = 12'h000;
        end
        // Four converter clocks per conversion while soc stays high
        always @(posedge conv_clk)
        begin
            if (conv_ctl[i].pd || !conv_ctl[i].soc)
            begin
                cnt         <= 2'h0;
                conv_eoc[i] <= 1'b0;
            end
            else
            begin
                cnt         <= cnt + 2'h1;
                conv_eoc[i] <= (cnt == 2'h3);
            end
            // Result only beside eoc; inverted otherwise so stale data never matches
            if (!conv_ctl[i].pd && conv_ctl[i].soc && cnt == 2'h3)
                conv_dout[i] <= {conv_ctl[i].tsen, 6'h00, conv_ctl[i].sel};
            else
                conv_dout[i] <= ~conv_dout[i];
        end
    end
endmodule : adc_hard_model
`default_nettype wire

// file: verif/adc_sequencer_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_sequencer_controller_bench
    import adc_seq_pkg::*;
();
    typedef struct packed {
        logic [CH_W-1:0]   ch;
        logic [DATA_W-1:0] data;
        logic              above;
        logic              below;
    } row_type;
    localparam row_type ROWS [4] = '{'{5'h03, 12'h003, 1'b0, 1'b0},
        '{5'h11, 12'h800, 1'b1, 1'b0}, '{5'h1f, 12'h01f, 1'b1, 1'b0},
        '{5'h00, 12'h000, 1'b0, 1'b1}};

    logic mclk, reset, run_set, run_clr, mode_cont, pwr_down_req;
    logic irq_en, irq_ack, conv_clk, run_bit, busy, irq, resp_valid, viol_valid;
    logic [SLOT_W-1:0]         rd_addr;
    logic [NCONV*DATA_W-1:0]   rd_data;
    resp_type                  resp;
    viol_type                  viol;
    logic [NCONV-1:0]          conv_eoc;
    sample_type                conv_dout;
    hard_ctl_type [NCONV-1:0]  conv_ctl;
    int                        mismatches;
    int                        total_checks;
    int                        n;
    int                        j;
    resp_type                  rq [$];
    viol_type                  vq [$];

    // ==========================================================
    // Design and converter
    adc_sequencer_controller #(
        .SEQ_LEN (4),
        .SLOT_CH (slot_tbl_type'({5'h00, 5'h1f, 5'h11, 5'h03})),
        .MAX_EN  (ch_mask_type'(64'h0000_0000_8002_0000)),
        .MIN_EN  (ch_mask_type'(64'h0000_0000_0000_0001)),
        .TH_MAX  (sample_type'(24'hff_f01e)),
        .TH_MIN  (sample_type'(24'h00_0001))
    ) dut_u (.mclk(mclk), .reset(reset), .run_set(run_set), .run_clr(run_clr),
        .mode_cont(mode_cont), .pwr_down_req(pwr_down_req), .run_bit(run_bit),
        .busy(busy), .rd_addr(rd_addr), .rd_data(rd_data), .irq_en(irq_en),
        .irq_ack(irq_ack), .irq(irq), .resp_valid(resp_valid), .resp(resp),
        .viol_valid(viol_valid), .viol(viol), .conv_clk(conv_clk),
        .conv_eoc(conv_eoc), .conv_dout(conv_dout), .conv_ctl(conv_ctl));
    adc_hard_model model_u (.conv_clk(conv_clk), .conv_ctl(conv_ctl),
        .conv_eoc(conv_eoc), .conv_dout(conv_dout));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        conv_clk = 1'b0;
        #130;
        forever #400 conv_clk = ~conv_clk;
    end

    // Responses cannot be stalled, so every valid cycle is taken
    always @(negedge mclk)
    begin
        if (resp_valid === 1'b1)
            rq.push_back(resp);
        if (viol_valid === 1'b1)
            vq.push_back(viol);
    end

    // ==========================================================
    // Tasks
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        total_checks++;
        if (act !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic limit(input int k, input int lim);
        if (k >= lim)
        begin
            mismatches++;
            $display("MISMATCH at %0t: wait bound used up, got %h limit %h", $time, k, lim);
            finish_test();
        end
    endtask : limit

    task automatic wait_idle;
        n = 0;
        while ((run_bit !== 1'b0 || busy !== 1'b0) && n < 5000)
        begin
            step(1);
            n++;
        end
        limit(n, 5000);
        step(30);
    endtask : wait_idle

    task automatic start(input logic cont);
        mode_cont = cont;
        run_set   = 1'b1;
        step(1);
        run_set   = 1'b0;
        step(3);
    endtask : start

    // ==========================================================
    // Sequence
    initial
    begin
        mismatches = 0;
        total_checks = 0;
        {run_set, run_clr, mode_cont, pwr_down_req, irq_en, irq_ack} = 6'h00;
        rd_addr = 6'h00;
        reset   = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        reset = 1'b0;
        check(conv_ctl[0].pd, 1'b1);
        irq_en = 1'b1;
        start(1'b0);
        wait_idle();
        check(rq.size(), 4);
        j = 0;
        for (int i = 0; i < 4; i++)
        begin
            rd_addr = 6'(i);
            step(2);
            check(rq[i].ch, ROWS[i].ch);
            check(rq[i].data[0], ROWS[i].data);
            check({rq[i].sop, rq[i].eop}, {i == 0, i == 3});
            check(rd_data[DATA_W-1:0], ROWS[i].data);
            if (ROWS[i].above || ROWS[i].below)
            begin
                check(vq[j].ch, ROWS[i].ch);
                check({vq[j].above[0], vq[j].below[0]}, {ROWS[i].above, ROWS[i].below});
                j++;
            end
        end
        check(vq.size(), 3);
        check(conv_ctl[1].pd, 1'b1);
        check(irq, 1'b1);
        irq_ack = 1'b1;
        step(1);
        irq_ack = 1'b0;
        step(1);
        check(irq, 1'b0);
        $display("Single pass test done");
        rq.delete();
        irq_en = 1'b0;
        start(1'b1);
        n = 0;
        while (rq.size() < 6 && n < 3000)
        begin
            step(1);
            n++;
        end
        limit(n, 3000);
        run_clr = 1'b1;
        step(1);
        run_clr = 1'b0;
        wait_idle();
        check(rq.size(), 8);
        foreach (rq[i])
            check(rq[i].ch, ROWS[i % 4].ch);
        check(irq, 1'b0);
        irq_en = 1'b1;
        step(1);
        check(irq, 1'b1);
        $display("Continuous test done");
        // Power down is only honoured while idle, so it is raised between runs
        pwr_down_req = 1'b1;
        rq.delete();
        step(20);
        check(conv_ctl[0].pd, 1'b1);
        start(1'b0);
        step(100);
        check(rq.size(), 0);
        reset = 1'b1;
        step(1);
        check({run_bit, busy, irq, resp_valid}, 4'h0);
        reset = 1'b0;
        pwr_down_req = 1'b0;
        step(2);
        $display("Power down and reset test done");
        finish_test();
    end
endmodule : adc_sequencer_controller_bench
`default_nettype wire
